// *** accel_regs_pkg.sv ***
/*
 * Shared constants for the rate, motion control and queue status registers.
 * Assumes an 8-bit register port, and queue pointers from logic on the same clock.
 */
package accel_regs_pkg;

    // Register port widths
    localparam int unsigned REG_ADDR_W = 8;
    localparam int unsigned REG_DATA_W = 8;

    // Register offsets
    localparam logic [7:0] SAMPLE_RATE_OFFSET = 8'h08;
    localparam logic [7:0] MOTION_CTRL_OFFSET = 8'h09;
    localparam logic [7:0] QUEUE_STATUS_OFFSET = 8'h0a;

    // Reset values
    localparam logic [7:0] SAMPLE_RATE_RESET = 8'h00;
    localparam logic [7:0] MOTION_CTRL_RESET = 8'h00;
    localparam logic [7:0] QUEUE_STATUS_RESET = 8'h01;

    // Sample rate fields
    localparam int unsigned RATE_CODE_LSB = 0;
    localparam int unsigned RATE_CODE_W = 3;
    localparam int unsigned RATE_FAST_BIT = 3;
    localparam int unsigned RATE_SLOW_BIT = 4;
    localparam logic [2:0] RATE_FAST_MISSING_CODE = 3'h7;
    localparam logic [2:0] RATE_FAST_INDEX_STEP = 3'h1;

    // Motion control fields
    localparam int unsigned MC_TILTFLIP_BIT = 0;
    localparam int unsigned MC_LATCH_BIT = 1;
    localparam int unsigned MC_ANY_MOVE_BIT = 2;
    localparam int unsigned MC_SHAKE_BIT = 3;
    localparam int unsigned MC_TILT35_BIT = 4;
    localparam int unsigned MC_POLARITY_BIT = 5;
    localparam int unsigned MC_UNFILTERED_BIT = 6;
    localparam int unsigned MC_RESET_BIT = 7;

    // Queue status fields
    localparam int unsigned QS_EMPTY_BIT = 0;
    localparam int unsigned QS_FULL_BIT = 1;
    localparam int unsigned QS_LEVEL_BIT = 2;
    localparam int unsigned QS_RSVD_LSB = 3;
    localparam int unsigned QS_RSVD_MSB = 7;

    // Queue pointer layout: address bits plus one wrap bit
    localparam int unsigned QPTR_W = 6;
    localparam int unsigned QADDR_W = 5;

    // Motion interrupt sources, in interrupt enable bit order
    localparam int unsigned INT_SRC_W = 5;
    localparam int unsigned INT_TILT_BIT = 0;
    localparam int unsigned INT_FLIP_BIT = 1;
    localparam int unsigned INT_ANY_MOVE_BIT = 2;
    localparam int unsigned INT_SHAKE_BIT = 3;
    localparam int unsigned INT_TILT35_BIT = 4;

    // Oscillator range picked by the rate register
    typedef enum logic [0:0] {
        RANGE_SLOW = 1'b0,
        RANGE_FAST = 1'b1
    } rate_range_t;

endpackage : accel_regs_pkg

// *** rate_code_decode.sv ***
/*
 * Decodes the sample rate register into a common rate index and range.
 * Assumes the caller registers the results; this module is purely combinational.
 */
`timescale 1ns/1ps
module rate_code_decode
    import accel_regs_pkg::*;
(
    input wire logic [7:0] i_rate_value,
    output logic [RATE_CODE_W-1:0] o_rate_index,
    output rate_range_t o_range,
    output logic o_legal
);
    logic [RATE_CODE_W-1:0] code;
    logic fast_sel;

    // Only the fast bit alone selects the fast table; anything else reads as slow
    assign code = i_rate_value[RATE_CODE_LSB +: RATE_CODE_W];
    assign fast_sel = i_rate_value[RATE_FAST_BIT] & ~i_rate_value[RATE_SLOW_BIT];
    assign o_range = fast_sel ? RANGE_FAST : RANGE_SLOW;

    // Fast table starts one step up the slow ladder, so both share one index
    assign o_rate_index = fast_sel ? code + RATE_FAST_INDEX_STEP : code;
    assign o_legal = !(fast_sel && (code == RATE_FAST_MISSING_CODE));

endmodule : rate_code_decode

// *** queue_level_flags.sv ***
/*
 * Empty, full and threshold flags from the queue's wrap-bit pointers.
 * Assumes both pointers come from logic on the same clock; outputs are unregistered.
 */
`timescale 1ns/1ps
module queue_level_flags
    import accel_regs_pkg::*;
(
    input wire logic [QPTR_W-1:0] i_wr_ptr,
    input wire logic [QPTR_W-1:0] i_rd_ptr,
    input wire logic [QPTR_W-1:0] i_threshold,
    output logic o_empty,
    output logic o_full,
    output logic o_level_reached
);
    logic addr_match;
    logic wrap_match;
    logic [QPTR_W-1:0] level;

    // Address and wrap comparison decide full against empty
    assign addr_match = i_wr_ptr[QADDR_W-1:0] == i_rd_ptr[QADDR_W-1:0];
    assign wrap_match = i_wr_ptr[QADDR_W] == i_rd_ptr[QADDR_W];
    assign o_empty = addr_match & wrap_match;
    assign o_full = addr_match & ~wrap_match;

    // Modulo difference spans 0..32 thanks to the wrap bit
    assign level = i_wr_ptr - i_rd_ptr;
    assign o_level_reached = level >= i_threshold;

endmodule : queue_level_flags

// *** accel_rate_motion_fifo_regs.sv ***
/*
 * Sample rate, motion control and queue status registers of the accelerometer.
 * Assumes a single-cycle register port from the serial front end, queue
 * pointers and threshold from the queue on the same clock, and raw motion
 * events and interrupt enables from the motion block and enable register.
 */
`timescale 1ns/1ps
module accel_rate_motion_fifo_regs
(
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic [accel_regs_pkg::REG_ADDR_W-1:0] i_reg_addr,
    input wire logic [accel_regs_pkg::REG_DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    output logic [accel_regs_pkg::REG_DATA_W-1:0] o_reg_rdata,
    input wire logic [accel_regs_pkg::QPTR_W-1:0] i_queue_wr_ptr,
    input wire logic [accel_regs_pkg::QPTR_W-1:0] i_queue_rd_ptr,
    input wire logic [accel_regs_pkg::QPTR_W-1:0] i_queue_threshold,
    input wire logic [accel_regs_pkg::INT_SRC_W-1:0] i_int_enable,
    input wire logic [accel_regs_pkg::INT_SRC_W-1:0] i_motion_event,
    output logic [accel_regs_pkg::RATE_CODE_W-1:0] o_output_sample_rate,
    output logic [accel_regs_pkg::RATE_CODE_W-1:0] o_internal_sample_rate,
    output logic o_osc_fast_range,
    output logic o_rate_code_illegal,
    output logic o_tiltflip_enable,
    output logic o_motion_latch,
    output logic o_any_movement_enable,
    output logic o_shake_enable,
    output logic o_tilt35_enable,
    output logic o_vertical_polarity,
    output logic o_unfiltered_flag_select,
    output logic o_motion_reset,
    output logic [accel_regs_pkg::INT_SRC_W-1:0] o_motion_int_status,
    output logic o_queue_empty,
    output logic o_queue_full,
    output logic o_queue_level_reached
);
    import accel_regs_pkg::*;

    // Address match used by both the write and read paths
    function automatic logic reg_hit(
        input logic [REG_ADDR_W-1:0] addr,
        input logic [REG_ADDR_W-1:0] offset
    );
        reg_hit = addr == offset;
    endfunction : reg_hit

    logic [REG_DATA_W-1:0] sample_rate_select_reg;
    logic [REG_DATA_W-1:0] sample_rate_select_next;
    logic [REG_DATA_W-1:0] motion_feature_control_reg;
    logic [REG_DATA_W-1:0] motion_feature_control_next;
    logic [RATE_CODE_W-1:0] rate_index_reg;
    logic [RATE_CODE_W-1:0] rate_index_next;
    rate_range_t range_reg;
    rate_range_t range_next;
    logic illegal_reg;
    logic illegal_next;

    logic rate_write;
    logic motion_write;
    logic [RATE_CODE_W-1:0] dec_index;
    rate_range_t dec_range;
    logic dec_legal;
    logic any_move_on;
    logic [INT_SRC_W-1:0] feature_on;
    logic [REG_DATA_W-1:0] queue_status;
    logic [REG_DATA_W-1:0] rdata_mux;

    // Write strobes; the read strobe has no side effect in this group
    assign rate_write = i_reg_write & reg_hit(i_reg_addr, SAMPLE_RATE_OFFSET);
    assign motion_write = i_reg_write & reg_hit(i_reg_addr, MOTION_CTRL_OFFSET);

    // Rate bits 7:5 are stored as written; keeping them zero is up to software
    assign sample_rate_select_next = rate_write ? i_reg_wdata : sample_rate_select_reg;
    // Reset bit only changes on a host write, never by itself
    assign motion_feature_control_next =
        motion_write ? i_reg_wdata : motion_feature_control_reg;

    // Register storage
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            sample_rate_select_reg <= SAMPLE_RATE_RESET;
            motion_feature_control_reg <= MOTION_CTRL_RESET;
        end
        else
        begin
            sample_rate_select_reg <= sample_rate_select_next;
            motion_feature_control_reg <= motion_feature_control_next;
        end
    end

    // Rate decode into one index shared by both interface speed tables
    rate_code_decode u_rate_decode
    (
        .i_rate_value(sample_rate_select_reg),
        .o_rate_index(dec_index),
        .o_range(dec_range),
        .o_legal(dec_legal)
    );

    // An undefined fast code keeps the last good rate so the oscillator never stalls
    assign rate_index_next = dec_legal ? dec_index : rate_index_reg;
    assign range_next = dec_legal ? dec_range : range_reg;
    assign illegal_next = ~dec_legal;

    // Applied rate and oscillator range, one cycle behind the register
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rate_index_reg <= '0;
            range_reg <= RANGE_SLOW;
            illegal_reg <= 1'b0;
        end
        else
        begin
            rate_index_reg <= rate_index_next;
            range_reg <= range_next;
            illegal_reg <= illegal_next;
        end
    end

    // Output and internal rates are the same setting
    assign o_output_sample_rate = rate_index_reg;
    assign o_internal_sample_rate = rate_index_reg;
    assign o_osc_fast_range = range_reg == RANGE_FAST;
    assign o_rate_code_illegal = illegal_reg;

    // Motion feature controls from the register bits; shake and tilt-35 also need any-motion
    assign o_tiltflip_enable = motion_feature_control_reg[MC_TILTFLIP_BIT];
    assign o_motion_latch = motion_feature_control_reg[MC_LATCH_BIT];
    assign any_move_on = motion_feature_control_reg[MC_ANY_MOVE_BIT];
    assign o_any_movement_enable = any_move_on;
    // Shake and tilt-35 ride on the any-motion detector, so gate them by it
    assign o_shake_enable = motion_feature_control_reg[MC_SHAKE_BIT] & any_move_on;
    assign o_tilt35_enable = motion_feature_control_reg[MC_TILT35_BIT] & any_move_on;
    assign o_vertical_polarity = motion_feature_control_reg[MC_POLARITY_BIT];
    assign o_unfiltered_flag_select = motion_feature_control_reg[MC_UNFILTERED_BIT];
    assign o_motion_reset = motion_feature_control_reg[MC_RESET_BIT];

    // Feature enables in interrupt source order; reset silences all reporting
    assign feature_on[INT_TILT_BIT] = o_tiltflip_enable;
    assign feature_on[INT_FLIP_BIT] = o_tiltflip_enable;
    assign feature_on[INT_ANY_MOVE_BIT] = any_move_on;
    assign feature_on[INT_SHAKE_BIT] = o_shake_enable;
    assign feature_on[INT_TILT35_BIT] = o_tilt35_enable;
    assign o_motion_int_status =
        i_motion_event & i_int_enable & feature_on & {INT_SRC_W{~o_motion_reset}};

    // Queue flags, unregistered so they track the pointers directly
    queue_level_flags u_queue_flags
    (
        .i_wr_ptr(i_queue_wr_ptr),
        .i_rd_ptr(i_queue_rd_ptr),
        .i_threshold(i_queue_threshold),
        .o_empty(o_queue_empty),
        .o_full(o_queue_full),
        .o_level_reached(o_queue_level_reached)
    );

    // No queue interrupt enable enters here, so flags never depend on one
    assign queue_status[QS_EMPTY_BIT] = o_queue_empty;
    assign queue_status[QS_FULL_BIT] = o_queue_full;
    assign queue_status[QS_LEVEL_BIT] = o_queue_level_reached;
    assign queue_status[QS_RSVD_MSB:QS_RSVD_LSB] = '0;

    // Read mux: motion control is write-only and unmapped offsets read zero
    assign rdata_mux =
        reg_hit(i_reg_addr, SAMPLE_RATE_OFFSET) ? sample_rate_select_reg :
        reg_hit(i_reg_addr, QUEUE_STATUS_OFFSET) ? queue_status : '0;
    // Combinational so status is seen live, even mid-read
    assign o_reg_rdata = i_reg_read ? rdata_mux : '0;

    // Checks on the block's own behaviour
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence rate_write_seq;
        rate_write ##1 1'b1;
    endsequence

    sequence slow_code_seq;
        sample_rate_select_reg[RATE_FAST_BIT] == 1'b0 ##1 1'b1;
    endsequence

    sequence fast_code_seq;
        sample_rate_select_reg[RATE_FAST_BIT] & ~sample_rate_select_reg[RATE_SLOW_BIT]
        ##1 1'b1;
    endsequence

    rate_store_a: assert property (rate_write_seq |-> ##1
        o_output_sample_rate == $past(dec_index) || o_rate_code_illegal)
        else $error("rate setting not applied after write");

    rate_slow_a: assert property (slow_code_seq |->
        o_output_sample_rate == $past(sample_rate_select_reg[2:0]) && !o_osc_fast_range)
        else $error("slow table rate index wrong");

    rate_fast_a: assert property (fast_code_seq |->
        o_rate_code_illegal ||
        (o_osc_fast_range &&
         o_output_sample_rate == $past(sample_rate_select_reg[2:0]) + RATE_FAST_INDEX_STEP))
        else $error("fast table rate index wrong");

    rate_hold_a: assert property (o_rate_code_illegal |->
        o_output_sample_rate == $past(o_output_sample_rate))
        else $error("undefined fast code changed the rate");

    motion_bits_a: assert property (motion_write |=>
        o_tiltflip_enable == $past(i_reg_wdata[MC_TILTFLIP_BIT]) &&
        o_unfiltered_flag_select == $past(i_reg_wdata[MC_UNFILTERED_BIT]) &&
        o_vertical_polarity == $past(i_reg_wdata[MC_POLARITY_BIT]))
        else $error("motion control write not taken");

    shake_gate_a: assert property (o_shake_enable |-> o_any_movement_enable)
        else $error("shake enabled without any-motion");

    tilt35_gate_a: assert property (o_tilt35_enable |-> o_any_movement_enable)
        else $error("tilt-35 enabled without any-motion");

    reset_hold_a: assert property (o_motion_reset && !motion_write |=> o_motion_reset)
        else $error("motion reset released without a write");

    int_gate_a: assert property (
        (o_motion_int_status & ~(i_int_enable & feature_on)) == '0)
        else $error("motion status reported while disabled");

    status_zero_a: assert property (
        i_reg_read && reg_hit(i_reg_addr, QUEUE_STATUS_OFFSET) |->
        o_reg_rdata[QS_RSVD_MSB:QS_RSVD_LSB] == '0 &&
        o_reg_rdata[QS_EMPTY_BIT] == o_queue_empty)
        else $error("queue status read wrong");

    queue_empty_a: assert property ((i_queue_wr_ptr == i_queue_rd_ptr) == o_queue_empty)
        else $error("empty flag disagrees with pointers");

    queue_full_a: assert property (
        o_queue_full == (i_queue_wr_ptr == (i_queue_rd_ptr ^ {1'b1, {QADDR_W{1'b0}}})))
        else $error("full flag disagrees with pointers");

    motion_ro_a: assert property (
        i_reg_read && reg_hit(i_reg_addr, MOTION_CTRL_OFFSET) |-> o_reg_rdata == '0)
        else $error("write-only motion control read back");

endmodule : accel_rate_motion_fifo_regs

// *** host_reg_model.sv ***
/*
 * Host processor model driving the single-cycle register port of the device.
 * Assumes the serial front end has already turned host traffic into strobes on the
 * device clock; requests start just after a rising edge and hold over the taking edge.
 */
`timescale 1ns/1ps
module host_reg_model
(
    input wire logic i_sys_clk,
    input wire logic [accel_regs_pkg::REG_DATA_W-1:0] i_reg_rdata,
    output logic [accel_regs_pkg::REG_ADDR_W-1:0] o_reg_addr,
    output logic [accel_regs_pkg::REG_DATA_W-1:0] o_reg_wdata,
    output logic o_reg_write,
    output logic o_reg_read
);
    import accel_regs_pkg::*;

    // Idle bus at time zero, no request pending
    initial
    begin
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
        o_reg_write = 1'b0;
        o_reg_read = 1'b0;
    end

    // One write, taken at the edge after launch; host software clears rate bits 7:5
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_sys_clk);
        #1;
        o_reg_addr = addr;
        o_reg_wdata = (addr == SAMPLE_RATE_OFFSET) ? (data & 8'h1f) : data;
        o_reg_write = 1'b1;
        @(posedge i_sys_clk);
        #1;
        o_reg_write = 1'b0;
        // Released lines carry garbage so stale values cannot pass unnoticed
        o_reg_addr = ~addr;
        o_reg_wdata = ~data;
    endtask : write_reg

    // One read; data is taken at the same edge that ends the request
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge i_sys_clk);
        #1;
        o_reg_addr = addr;
        o_reg_read = 1'b1;
        @(posedge i_sys_clk);
        data = i_reg_rdata;
        #1;
        o_reg_read = 1'b0;
        o_reg_addr = ~addr;
    endtask : read_reg
endmodule : host_reg_model

// *** accel_rate_motion_fifo_regs_bench.sv ***
/*
 * Self-checking bench for the rate, motion control and queue status registers.
 * Assumes the host model above for register traffic; queue pointers and motion
 * events are driven here in place of the queue and motion block.
 */
`timescale 1ns/1ps
module accel_rate_motion_fifo_regs_bench;
    import accel_regs_pkg::*;

    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_write, reg_read;
    logic [5:0] wr_ptr = 6'h00, rd_ptr = 6'h00, threshold = 6'h10;
    logic [4:0] int_en = 5'h00, mot_ev = 5'h00, mot_stat;
    logic [2:0] out_rate, int_rate;
    logic fast, illegal, tf_en, latch, any_en, shake_en, t35_en, vpol, unf, mreset;
    logic q_empty, q_full, q_level;
    logic [7:0] ctrl_seen;
    int fails = 0;
    int checks_done = 0;
    // Queue table: write pointer, read pointer, threshold, expected status
    logic [5:0] q_wr [10] = '{6'h00, 6'h20, 6'h10, 6'h0f, 6'h05, 6'h23, 6'h25, 6'h01, 6'h3f, 6'h00};
    logic [5:0] q_rd [10] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h25, 6'h03, 6'h25, 6'h00, 6'h20, 6'h3f};
    logic [5:0] q_th [10] = '{6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h10, 6'h01, 6'h10, 6'h10};
    logic [7:0] q_exp [10] = '{8'h01, 8'h06, 8'h04, 8'h00, 8'h06, 8'h06, 8'h01, 8'h04, 8'h04, 8'h00};

    always #4 sys_clk = ~sys_clk;
    assign ctrl_seen = {mreset, unf, vpol, t35_en, shake_en, any_en, latch, tf_en};

    host_reg_model i_host (.i_sys_clk(sys_clk), .i_reg_rdata(reg_rdata), .o_reg_addr(reg_addr),
        .o_reg_wdata(reg_wdata), .o_reg_write(reg_write), .o_reg_read(reg_read));

    accel_rate_motion_fifo_regs i_dut (.i_sys_clk(sys_clk), .i_reset_n(reset_n),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_write(reg_write),
        .i_reg_read(reg_read), .o_reg_rdata(reg_rdata), .i_queue_wr_ptr(wr_ptr),
        .i_queue_rd_ptr(rd_ptr), .i_queue_threshold(threshold), .i_int_enable(int_en),
        .i_motion_event(mot_ev), .o_output_sample_rate(out_rate),
        .o_internal_sample_rate(int_rate), .o_osc_fast_range(fast),
        .o_rate_code_illegal(illegal), .o_tiltflip_enable(tf_en), .o_motion_latch(latch),
        .o_any_movement_enable(any_en), .o_shake_enable(shake_en), .o_tilt35_enable(t35_en),
        .o_vertical_polarity(vpol), .o_unfiltered_flag_select(unf), .o_motion_reset(mreset),
        .o_motion_int_status(mot_stat), .o_queue_empty(q_empty), .o_queue_full(q_full),
        .o_queue_level_reached(q_level));

    // Compare of register read data
    task automatic chk_reg(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_reg

    // Compare of a side output, widened so unknown bits still show
    task automatic chk_out(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_out

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input string name);
        logic [7:0] data;
        i_host.read_reg(addr, data);
        chk_reg(name, exp, data);
    endtask : rd_chk

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    // Watchdog sized well above the under two hundred cycles the tests need
    initial
    begin
        #(8 * 3000);
        fails++;
        $display("[FAIL] watchdog expected finish seen hang");
        final_report();
    end

    initial
    begin
        repeat (4) @(posedge sys_clk);
        #1;
        reset_n = 1'b1;
        // Reset state
        chk_out("ctrl outputs", 8'h00, ctrl_seen);
        chk_out("rate index", 8'h00, {5'h0, out_rate});
        rd_chk(SAMPLE_RATE_OFFSET, SAMPLE_RATE_RESET, "rate reset");
        rd_chk(QUEUE_STATUS_OFFSET, QUEUE_STATUS_RESET, "status reset");
        rd_chk(MOTION_CTRL_OFFSET, 8'h00, "ctrl write only");
        // Slow interface table, every code
        for (int c = 0; c < 8; c++)
        begin
            i_host.write_reg(SAMPLE_RATE_OFFSET, 8'h10 + 8'(c));
            rd_chk(SAMPLE_RATE_OFFSET, 8'h10 + 8'(c), "rate readback");
            chk_out("out rate", 8'(c), {5'h0, out_rate});
            chk_out("osc rate", 8'(c), {5'h0, int_rate});
            chk_out("range illegal", 8'h00, {6'h0, fast, illegal});
        end
        // Fast interface table is one step up the common rate list
        for (int c = 0; c < 7; c++)
        begin
            i_host.write_reg(SAMPLE_RATE_OFFSET, 8'h08 + 8'(c));
            repeat (2) @(posedge sys_clk);
            #1;
            chk_out("fast rate", 8'(c + 1), {5'h0, out_rate});
            chk_out("fast range", 8'h02, {6'h0, fast, illegal});
        end
        // Undefined fast code keeps the last applied rate
        i_host.write_reg(SAMPLE_RATE_OFFSET, 8'h0f);
        rd_chk(SAMPLE_RATE_OFFSET, 8'h0f, "code7 readback");
        chk_out("code7 rate", 8'h07, {5'h0, out_rate});
        chk_out("code7 flag", 8'h01, {7'h0, illegal});
        // Read-only and unmapped places ignore writes
        i_host.write_reg(QUEUE_STATUS_OFFSET, 8'hfe);
        rd_chk(QUEUE_STATUS_OFFSET, 8'h01, "status after write");
        i_host.write_reg(8'h20, 8'h55);
        rd_chk(8'h20, 8'h00, "unmapped read");
        rd_chk(SAMPLE_RATE_OFFSET, 8'h0f, "rate untouched");
        // Each control bit alone; shake and tilt-35 need any-motion as well
        for (int b = 0; b < 8; b++)
        begin
            i_host.write_reg(MOTION_CTRL_OFFSET, 8'h01 << b);
            @(posedge sys_clk);
            #1;
            chk_out("ctrl bit", (b == 3 || b == 4) ? 8'h00 : 8'h01 << b, ctrl_seen);
        end
        i_host.write_reg(MOTION_CTRL_OFFSET, 8'h0c);
        #8;
        chk_out("shake pair", 8'h0c, ctrl_seen);
        i_host.write_reg(MOTION_CTRL_OFFSET, 8'h14);
        #8;
        chk_out("tilt35 pair", 8'h14, ctrl_seen);
        // Motion status gated by feature and interrupt enables
        i_host.write_reg(MOTION_CTRL_OFFSET, 8'h1d);
        int_en = 5'h1f;
        mot_ev = 5'h1f;
        #8;
        chk_out("status all", 8'h1f, {3'h0, mot_stat});
        int_en = 5'h0a;
        #1;
        chk_out("status masked", 8'h0a, {3'h0, mot_stat});
        int_en = 5'h1f;
        i_host.write_reg(MOTION_CTRL_OFFSET, 8'h09);
        #8;
        chk_out("status no any", 8'h03, {3'h0, mot_stat});
        // Motion reset holds until software rewrites it
        i_host.write_reg(MOTION_CTRL_OFFSET, 8'h9d);
        repeat (6) @(posedge sys_clk);
        #1;
        chk_out("reset held", 8'h01, {7'h0, mreset});
        chk_out("status in reset", 8'h00, {3'h0, mot_stat});
        i_host.write_reg(MOTION_CTRL_OFFSET, 8'h1d);
        #8;
        chk_out("reset released", 8'h00, {7'h0, mreset});
        // Queue flags follow the pointers in the same cycle
        for (int i = 0; i < 10; i++)
        begin
            @(posedge sys_clk);
            #1;
            wr_ptr = q_wr[i];
            rd_ptr = q_rd[i];
            threshold = q_th[i];
            #1;
            chk_out("queue flags", q_exp[i], {5'h0, q_level, q_full, q_empty});
            rd_chk(QUEUE_STATUS_OFFSET, q_exp[i], "queue status");
        end
        // Second reset mid-run restores defaults
        reset_n = 1'b0;
        #8;
        reset_n = 1'b1;
        chk_out("rate after reset", 8'h00, {5'h0, out_rate, 8'h0} >> 8);
        rd_chk(SAMPLE_RATE_OFFSET, 8'h00, "rate reg after reset");
        final_report();
    end
endmodule : accel_rate_motion_fifo_regs_bench
